// ### rtl/tw_dev.sv
// Device end of the three-wire EEPROM: decoder, array, self-timed cycle and status.
`timescale 1ns/1ps
`default_nettype none

module tw_dev #(
	parameter int MEM_BYTES = tw_pkg::MEM_BYTES,
	parameter int PROG_CYC = tw_pkg::PROG_CYC
) (
	input wire logic I_MCLK,
	input wire logic I_RESET_N,
	output logic O_BUSY,
	tw_if.dev LINK
);
	localparam logic [8:0] AMASK = 9'(MEM_BYTES - 1);
	localparam int TW = $clog2(PROG_CYC + 1);

	logic [7:0] mem [MEM_BYTES];
	logic frame_rst_n;
	logic wide_s1_r, wide_s2_r, bsy_s1_r, bsy_s2_r;
	tw_pkg::tw_dst_t state_r;
	logic [4:0] cnt_r, aw, dw;
	logic [15:0] sh_r, d_in, rd_word_r;
	logic [1:0] op_r, sub;
	logic [8:0] a_full, a_in, addr_r;
	logic rd_oe_r, rd_bit_r, addr_end, data_end, en_r, issue;
	logic tgl_r, cmd_wide_r;
	logic [1:0] cmd_kind_r;
	logic [8:0] cmd_addr_r;
	logic [15:0] cmd_data_r, wd;
	logic tg_s1_r, tg_s2_r, tg_s3_r, sel_s1_r, sel_s2_r, sel_s3_r;
	logic oe_s1_r, oe_s2_r, bit_s1_r, bit_s2_r, go;
	logic busy_r, show_r, do_r, oe_r;
	logic [TW-1:0] tmr_r;

	// Byte address of a word; the top address bit folds away on a small array.
	function automatic logic [8:0] byte_addr(input logic [8:0] a, input logic w);
		byte_addr = (w ? {a[7:0], 1'h0} : a) & AMASK;
	endfunction

	// Word read from the array in the current width.
	function automatic logic [15:0] fetch(input logic [8:0] a, input logic w);
		logic [8:0] ba;
		ba = byte_addr(a, w);
		fetch = w ? {mem[ba], mem[ba | 9'h1]} : {8'h00, mem[ba]};
	endfunction

	// The frame logic is held in reset whenever select is low.
	assign frame_rst_n = I_RESET_N & LINK.select_pin;
	assign aw = wide_s2_r ? tw_pkg::ADDR_BITS_X16 : tw_pkg::ADDR_BITS_X8;
	assign dw = wide_s2_r ? tw_pkg::DATA_BITS_X16 : tw_pkg::DATA_BITS_X8;
	assign a_full = {sh_r[7:0], LINK.serial_in_pin};
	assign a_in = wide_s2_r ? {1'h0, a_full[7:0]} : a_full;
	assign sub = wide_s2_r ? a_full[7:6] : a_full[8:7];
	assign d_in = wide_s2_r ? {sh_r[14:0], LINK.serial_in_pin} : {8'h00, sh_r[6:0], LINK.serial_in_pin};
	assign addr_end = (state_r == tw_pkg::DS_ADDR) && (cnt_r == 5'h0);
	assign data_end = (state_r == tw_pkg::DS_DATA) && (cnt_r == 5'h0);

	// Width strap, synchronised on the shift clock and kept across frames.
	always_ff @(posedge LINK.shift_clock_pin or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			wide_s1_r <= 1'h1;
			wide_s2_r <= 1'h1;
		end else begin
			wide_s1_r <= LINK.width_select_pin;
			wide_s2_r <= wide_s1_r;
		end
	end

	// Busy seen from the link; assumed busy until two edges have passed.
	always_ff @(posedge LINK.shift_clock_pin or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bsy_s1_r <= 1'h1;
			bsy_s2_r <= 1'h1;
		end else begin
			bsy_s1_r <= busy_r;
			bsy_s2_r <= bsy_s1_r;
		end
	end

	// Frame decoder and read shifter; the output bit changes only on rises.
	always_ff @(posedge LINK.shift_clock_pin or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			state_r <= tw_pkg::DS_IDLE;
			cnt_r <= 5'h0;
			sh_r <= 16'h0000;
			op_r <= 2'h0;
			addr_r <= 9'h000;
			rd_word_r <= 16'h0000;
			rd_oe_r <= 1'h0;
			rd_bit_r <= 1'h0;
		end else begin
			sh_r <= {sh_r[14:0], LINK.serial_in_pin};
			case (state_r)
				tw_pkg::DS_IDLE: begin
					if (LINK.serial_in_pin == tw_pkg::START_BIT) begin
						state_r <= tw_pkg::DS_OPC;
						cnt_r <= 5'h1;
					end
				end
				tw_pkg::DS_OPC: begin
					if (cnt_r == 5'h0) begin
						op_r <= {sh_r[0], LINK.serial_in_pin};
						state_r <= tw_pkg::DS_ADDR;
						cnt_r <= aw - 5'h1;
					end else begin
						cnt_r <= cnt_r - 5'h1;
					end
				end
				tw_pkg::DS_ADDR: begin
					if (cnt_r != 5'h0) begin
						cnt_r <= cnt_r - 5'h1;
					end else if (bsy_s2_r) begin
						state_r <= tw_pkg::DS_SKIP;
					end else if (op_r == tw_pkg::OP_READ) begin
						rd_oe_r <= 1'h1;
						rd_bit_r <= 1'h0;
						rd_word_r <= fetch(a_in, wide_s2_r);
						addr_r <= a_in;
						cnt_r <= dw - 5'h1;
						state_r <= tw_pkg::DS_READ;
					end else if (op_r == tw_pkg::OP_WRITE ||
						(op_r == tw_pkg::OP_SPECIAL && sub == tw_pkg::SUB_WRITE_ALL)) begin
						addr_r <= a_in;
						cnt_r <= dw - 5'h1;
						state_r <= tw_pkg::DS_DATA;
					end else begin
						state_r <= tw_pkg::DS_SKIP;
					end
				end
				tw_pkg::DS_DATA: begin
					if (cnt_r == 5'h0) begin
						state_r <= tw_pkg::DS_SKIP;
					end else begin
						cnt_r <= cnt_r - 5'h1;
					end
				end
				tw_pkg::DS_READ: begin
					rd_bit_r <= rd_word_r[cnt_r[3:0]];
					if (cnt_r == 5'h0) begin
						addr_r <= addr_r + 9'h001;
						rd_word_r <= fetch(addr_r + 9'h001, wide_s2_r);
						cnt_r <= dw - 5'h1;
					end else begin
						cnt_r <= cnt_r - 5'h1;
					end
				end
				tw_pkg::DS_SKIP: begin
					state_r <= tw_pkg::DS_SKIP;
				end
				default: begin
					state_r <= tw_pkg::DS_IDLE;
				end
			endcase
		end
	end

	// Program enable latch; only reset and the disable command clear it.
	always_ff @(posedge LINK.shift_clock_pin or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			en_r <= 1'h0;
		end else if (addr_end && !bsy_s2_r && op_r == tw_pkg::OP_SPECIAL) begin
			if (sub == tw_pkg::SUB_ENABLE) begin
				en_r <= 1'h1;
			end else if (sub == tw_pkg::SUB_DISABLE) begin
				en_r <= 1'h0;
			end
		end
	end

	// A programming command is issued only while the latch is set.
	assign issue = en_r && !bsy_s2_r && (data_end || (addr_end && (op_r == tw_pkg::OP_ERASE ||
		(op_r == tw_pkg::OP_SPECIAL && sub == tw_pkg::SUB_ERASE_ALL))));

	// Command payload, held stable and announced by a toggle.
	always_ff @(posedge LINK.shift_clock_pin or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			tgl_r <= 1'h0;
			cmd_kind_r <= tw_pkg::PK_WRITE;
			cmd_addr_r <= 9'h000;
			cmd_data_r <= 16'h0000;
			cmd_wide_r <= 1'h1;
		end else if (issue) begin
			tgl_r <= ~tgl_r;
			cmd_wide_r <= wide_s2_r;
			cmd_data_r <= d_in;
			cmd_addr_r <= addr_end ? a_in : addr_r;
			if (addr_end) begin
				cmd_kind_r <= (op_r == tw_pkg::OP_ERASE) ? tw_pkg::PK_ERASE : tw_pkg::PK_ERASE_ALL;
			end else begin
				cmd_kind_r <= (op_r == tw_pkg::OP_WRITE) ? tw_pkg::PK_WRITE : tw_pkg::PK_WRITE_ALL;
			end
		end
	end

	// Crossings into the system clock domain.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			tg_s1_r <= 1'h0;
			tg_s2_r <= 1'h0;
			tg_s3_r <= 1'h0;
			sel_s1_r <= 1'h0;
			sel_s2_r <= 1'h0;
			sel_s3_r <= 1'h0;
			oe_s1_r <= 1'h0;
			oe_s2_r <= 1'h0;
			bit_s1_r <= 1'h0;
			bit_s2_r <= 1'h0;
		end else begin
			tg_s1_r <= tgl_r;
			tg_s2_r <= tg_s1_r;
			tg_s3_r <= tg_s2_r;
			sel_s1_r <= LINK.select_pin;
			sel_s2_r <= sel_s1_r;
			sel_s3_r <= sel_s2_r;
			oe_s1_r <= rd_oe_r;
			oe_s2_r <= oe_s1_r;
			bit_s1_r <= rd_bit_r;
			bit_s2_r <= bit_s1_r;
		end
	end
	assign go = tg_s2_r ^ tg_s3_r;

	// Self-timed cycle: busy for exactly PROG_CYC system clocks.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			busy_r <= 1'h0;
			tmr_r <= '0;
		end else if (go) begin
			busy_r <= 1'h1;
			tmr_r <= TW'(PROG_CYC - 1);
		end else if (busy_r) begin
			if (tmr_r == '0) begin
				busy_r <= 1'h0;
			end else begin
				tmr_r <= tmr_r - 1'b1;
			end
		end
	end

	// Array update at the start of the cycle; erase data is all ones.
	assign wd = (cmd_kind_r == tw_pkg::PK_ERASE || cmd_kind_r == tw_pkg::PK_ERASE_ALL) ?
		{tw_pkg::ERASED_BYTE, tw_pkg::ERASED_BYTE} : cmd_data_r;
	always_ff @(posedge I_MCLK) begin
		if (go) begin
			if (cmd_kind_r == tw_pkg::PK_WRITE || cmd_kind_r == tw_pkg::PK_ERASE) begin
				if (cmd_wide_r) begin
					mem[byte_addr(cmd_addr_r, 1'h1)] <= wd[15:8];
					mem[byte_addr(cmd_addr_r, 1'h1) | 9'h1] <= wd[7:0];
				end else begin
					mem[byte_addr(cmd_addr_r, 1'h0)] <= wd[7:0];
				end
			end else begin
				for (int i = 0; i < MEM_BYTES; i++) begin
					mem[i] <= (cmd_wide_r && !i[0]) ? wd[15:8] : wd[7:0];
				end
			end
		end
	end

	// Status is shown only if busy when select rises, until select falls.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			show_r <= 1'h0;
		end else if (!sel_s2_r) begin
			show_r <= 1'h0;
		end else if (sel_s2_r && !sel_s3_r) begin
			show_r <= busy_r;
		end
	end

	// Output pin flops: status while shown (low while busy, high once ready), else the read bit.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			do_r <= 1'h0;
			oe_r <= 1'h0;
		end else begin
			do_r <= show_r ? ~busy_r : bit_s2_r;
			oe_r <= sel_s2_r && (show_r || oe_s2_r);
		end
	end

	assign LINK.serial_out = do_r;
	assign LINK.serial_out_oe = oe_r;
	assign O_BUSY = busy_r;
endmodule // tw_dev
`default_nettype wire

// ### rtl/tw_host.sv
// Host end of the three-wire EEPROM link: frame builder, shift clock and status poll.
`timescale 1ns/1ps
`default_nettype none
module tw_host #(
	parameter int SHIFT_HALF_CYC = tw_pkg::SHIFT_HALF_CYC,
	parameter int SELECT_LOW_CYC = tw_pkg::SELECT_LOW_CYC,
	parameter int STATUS_VALID_CYC = tw_pkg::STATUS_VALID_CYC
) (
	input wire logic I_MCLK,
	input wire logic I_RESET_N,
	input wire logic I_CMD_VALID,
	input wire tw_pkg::tw_cmd_t I_CMD_KIND,
	input wire logic [8:0] I_CMD_ADDR,
	input wire logic [15:0] I_CMD_DATA,
	input wire logic [7:0] I_RD_WORDS,
	input wire logic I_WIDE,
	output logic O_CMD_READY,
	output logic O_RD_VALID,
	output logic [15:0] O_RD_DATA,
	output logic O_DONE,
	tw_if.host LINK
);
	tw_pkg::tw_hst_t state_r;
	logic [27:0] tx_r, fr_c;
	logic [12:0] k_r, last_r, first_r, f_c;
	logic [15:0] tmr_r, rx_r;
	logic [4:0] nrx_r, dw_r, aw_c, dw_c;
	logic [1:0] op_c, sub_c;
	logic [8:0] af_c;
	logic rd_r, prog_r, polled_r, ser_s1_r, ser_s2_r;
	logic sk_r, cs_r, si_r, org_r;

	// Frame for the requested command, left aligned, start bit first.
	always_comb begin
		op_c = tw_pkg::OP_SPECIAL;
		sub_c = tw_pkg::SUB_DISABLE;
		case (I_CMD_KIND)
			tw_pkg::CMD_READ: op_c = tw_pkg::OP_READ;
			tw_pkg::CMD_WRITE: op_c = tw_pkg::OP_WRITE;
			tw_pkg::CMD_ERASE: op_c = tw_pkg::OP_ERASE;
			tw_pkg::CMD_ENABLE: sub_c = tw_pkg::SUB_ENABLE;
			tw_pkg::CMD_ERASE_ALL: sub_c = tw_pkg::SUB_ERASE_ALL;
			tw_pkg::CMD_WRITE_ALL: sub_c = tw_pkg::SUB_WRITE_ALL;
			default: sub_c = tw_pkg::SUB_DISABLE;
		endcase
		// Don't-care address bits are sent as zeros but always clocked.
		af_c = I_CMD_ADDR;
		if (op_c == tw_pkg::OP_SPECIAL) begin
			af_c = I_WIDE ? {1'h0, sub_c, 6'h00} : {sub_c, 7'h00};
		end
		fr_c = I_WIDE ? {tw_pkg::START_BIT, op_c, af_c[7:0], I_CMD_DATA, 1'h0} :
			{tw_pkg::START_BIT, op_c, af_c, I_CMD_DATA[7:0], 8'h00};
		aw_c = I_WIDE ? tw_pkg::ADDR_BITS_X16 : tw_pkg::ADDR_BITS_X8;
		dw_c = I_WIDE ? tw_pkg::DATA_BITS_X16 : tw_pkg::DATA_BITS_X8;
		f_c = 13'h3 + 13'(aw_c);
		if (I_CMD_KIND == tw_pkg::CMD_WRITE || I_CMD_KIND == tw_pkg::CMD_WRITE_ALL) begin
			f_c = f_c + 13'(dw_c);
		end
	end

	// Returned line, synchronised before use.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ser_s1_r <= 1'h1;
			ser_s2_r <= 1'h1;
		end else begin
			ser_s1_r <= LINK.serial_out_line;
			ser_s2_r <= ser_s1_r;
		end
	end

	// Sequencer: shift clock by division, select gap, then status poll.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			state_r <= tw_pkg::HS_IDLE;
			tx_r <= 28'h0;
			k_r <= 13'h0;
			last_r <= 13'h0;
			first_r <= 13'h0;
			tmr_r <= 16'h0;
			rx_r <= 16'h0;
			nrx_r <= 5'h0;
			dw_r <= 5'h0;
			rd_r <= 1'h0;
			prog_r <= 1'h0;
			polled_r <= 1'h0;
			sk_r <= 1'h0;
			cs_r <= 1'h0;
			si_r <= 1'h0;
			org_r <= 1'h1;
			O_CMD_READY <= 1'h1;
			O_RD_VALID <= 1'h0;
			O_RD_DATA <= 16'h0;
			O_DONE <= 1'h0;
		end else begin
			O_RD_VALID <= 1'h0;
			O_DONE <= 1'h0;
			case (state_r)
				tw_pkg::HS_IDLE: begin
					org_r <= I_WIDE;
					if (I_CMD_VALID) begin
						tx_r <= fr_c;
						si_r <= fr_c[27];
						cs_r <= 1'h1;
						k_r <= 13'h0;
						first_r <= f_c;
						rd_r <= (I_CMD_KIND == tw_pkg::CMD_READ);
						last_r <= f_c - 13'h1 + ((I_CMD_KIND == tw_pkg::CMD_READ) ?
							13'(dw_c) * 13'(I_RD_WORDS) : 13'h0);
						prog_r <= (I_CMD_KIND != tw_pkg::CMD_READ) && (I_CMD_KIND != tw_pkg::CMD_ENABLE)
							&& (I_CMD_KIND != tw_pkg::CMD_DISABLE);
						dw_r <= dw_c;
						nrx_r <= 5'h0;
						rx_r <= 16'h0;
						tmr_r <= 16'h0;
						polled_r <= 1'h0;
						O_CMD_READY <= 1'h0;
						state_r <= tw_pkg::HS_LOW;
					end
				end
				tw_pkg::HS_LOW: begin
					if (tmr_r == 16'(SHIFT_HALF_CYC - 1)) begin
						tmr_r <= 16'h0;
						sk_r <= 1'h1;
						state_r <= tw_pkg::HS_HIGH;
					end else begin
						tmr_r <= tmr_r + 16'h1;
					end
				end
				tw_pkg::HS_HIGH: begin
					if (tmr_r == 16'(SHIFT_HALF_CYC - 1)) begin
						tmr_r <= 16'h0;
						sk_r <= 1'h0;
						tx_r <= {tx_r[26:0], 1'h0};
						si_r <= tx_r[26];
						k_r <= k_r + 13'h1;
						// The sample at the last address clock is the dummy and is dropped.
						if (rd_r && k_r >= first_r) begin
							rx_r <= {rx_r[14:0], ser_s2_r};
							nrx_r <= nrx_r + 5'h1;
							if (nrx_r == dw_r - 5'h1) begin
								O_RD_VALID <= 1'h1;
								O_RD_DATA <= {rx_r[14:0], ser_s2_r};
								rx_r <= 16'h0;
								nrx_r <= 5'h0;
							end
						end
						if (k_r == last_r) begin
							cs_r <= 1'h0;
							si_r <= 1'h0;
							state_r <= tw_pkg::HS_GAP;
						end else begin
							state_r <= tw_pkg::HS_LOW;
						end
					end else begin
						tmr_r <= tmr_r + 16'h1;
					end
				end
				tw_pkg::HS_GAP: begin
					if (tmr_r == 16'(SELECT_LOW_CYC - 1)) begin
						tmr_r <= 16'h0;
						if (prog_r && !polled_r) begin
							cs_r <= 1'h1;
							state_r <= tw_pkg::HS_POLL;
						end else begin
							O_CMD_READY <= 1'h1;
							O_DONE <= 1'h1;
							state_r <= tw_pkg::HS_IDLE;
						end
					end else begin
						tmr_r <= tmr_r + 16'h1;
					end
				end
				tw_pkg::HS_POLL: begin
					if (tmr_r != 16'(STATUS_VALID_CYC)) begin
						tmr_r <= tmr_r + 16'h1;
					end else if (ser_s2_r) begin
						cs_r <= 1'h0;
						polled_r <= 1'h1;
						tmr_r <= 16'h0;
						state_r <= tw_pkg::HS_GAP;
					end
				end
				default: begin
					state_r <= tw_pkg::HS_IDLE;
				end
			endcase
		end
	end

	assign LINK.shift_clock_pin = sk_r;
	assign LINK.select_pin = cs_r;
	assign LINK.serial_in_pin = si_r;
	assign LINK.width_select_pin = org_r;
endmodule // tw_host
`default_nettype wire

// ### rtl/tw_if.sv
// Carrier that joins the host and device ends of the three-wire link.
`timescale 1ns/1ps
`default_nettype none
interface tw_if;
	logic shift_clock_pin;
	logic select_pin;
	logic serial_in_pin;
	logic width_select_pin;
	logic serial_out;
	logic serial_out_oe;
	logic serial_out_line;
	// An undriven output line reads high, as through a pull-up.
	assign serial_out_line = serial_out_oe ? serial_out : 1'h1;
	modport dev(input shift_clock_pin, input select_pin, input serial_in_pin,
		input width_select_pin, output serial_out, output serial_out_oe);
	modport host(output shift_clock_pin, output select_pin, output serial_in_pin,
		output width_select_pin, input serial_out_line);
endinterface
`default_nettype wire

// ### rtl/tw_pkg.sv
// Constants and types shared by both ends of the three-wire EEPROM link.
package tw_pkg;
	localparam logic START_BIT = 1'h1;
	localparam logic [1:0] OP_SPECIAL = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [1:0] SUB_DISABLE = 2'h0;
	localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
	localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
	localparam logic [1:0] SUB_ENABLE = 2'h3;
	localparam logic [4:0] ADDR_BITS_X8 = 5'h9;
	localparam logic [4:0] ADDR_BITS_X16 = 5'h8;
	localparam logic [4:0] DATA_BITS_X8 = 5'h8;
	localparam logic [4:0] DATA_BITS_X16 = 5'h10;
	localparam int MEM_BYTES = 512;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// Kinds of self-timed cycle passed to the system clock side.
	localparam logic [1:0] PK_WRITE = 2'h0;
	localparam logic [1:0] PK_ERASE = 2'h1;
	localparam logic [1:0] PK_ERASE_ALL = 2'h2;
	localparam logic [1:0] PK_WRITE_ALL = 2'h3;
	// Times in their own units and the derived cycle counts.
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SELECT_LOW_TIME_NS = 250;
	localparam int SELECT_LOW_CYC = (SELECT_LOW_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STATUS_VALID_NS = 250;
	localparam int STATUS_VALID_CYC = (STATUS_VALID_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SHIFT_HALF_NS = 250;
	localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PROG_CYCLE_TIME_MS = 10;
	localparam int PROG_CYC = int'(64'(PROG_CYCLE_TIME_MS) * 64'h3b9aca00 / 64'(CLK_PERIOD_PS));
	typedef enum logic [2:0] {
		CMD_READ = 3'h0,
		CMD_WRITE = 3'h1,
		CMD_ERASE = 3'h2,
		CMD_ENABLE = 3'h3,
		CMD_DISABLE = 3'h4,
		CMD_ERASE_ALL = 3'h5,
		CMD_WRITE_ALL = 3'h6
	} tw_cmd_t;
	typedef enum logic [2:0] {
		DS_IDLE = 3'h0,
		DS_OPC = 3'h1,
		DS_ADDR = 3'h3,
		DS_DATA = 3'h2,
		DS_READ = 3'h6,
		DS_SKIP = 3'h7
	} tw_dst_t;
	typedef enum logic [2:0] {
		HS_IDLE = 3'h0,
		HS_LOW = 3'h1,
		HS_HIGH = 3'h3,
		HS_GAP = 3'h2,
		HS_POLL = 3'h6
	} tw_hst_t;
endpackage

// ### testbench/tb.sv
// Self-checking bench joining the host and device ends over the three-wire link.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int PROG = 200;
	logic I_MCLK;
	logic I_RESET_N;
	logic cmd_valid;
	tw_pkg::tw_cmd_t cmd_kind;
	logic [8:0] cmd_addr;
	logic [15:0] cmd_data;
	logic [7:0] rd_words;
	logic wide;
	logic cmd_ready;
	logic rd_valid;
	logic [15:0] rd_data;
	logic done;
	logic busy;
	logic busy_seen;
	logic en;
	logic [7:0] mem [512];
	logic [16:0] expq [$];
	logic [31:0] seed;
	int err_count;
	int n_tests;
	int cyc;
	tw_if link();
	tw_host #(.SHIFT_HALF_CYC(8)) tw_host_i(.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N),
		.I_CMD_VALID(cmd_valid), .I_CMD_KIND(cmd_kind), .I_CMD_ADDR(cmd_addr),
		.I_CMD_DATA(cmd_data), .I_RD_WORDS(rd_words), .I_WIDE(wide), .O_CMD_READY(cmd_ready),
		.O_RD_VALID(rd_valid), .O_RD_DATA(rd_data), .O_DONE(done), .LINK(link));
	tw_dev #(.PROG_CYC(PROG)) tw_dev_i(.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .O_BUSY(busy),
		.LINK(link));
	tw_assertions #(.PROG_CYC(PROG)) tw_assertions_i(.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N),
		.shift_clock_pin(link.shift_clock_pin), .select_pin(link.select_pin),
		.serial_out(link.serial_out), .serial_out_oe(link.serial_out_oe), .O_BUSY(busy));
	// Makes the system clock.
	initial begin
		I_MCLK = 1'b0;
		forever #2.5 I_MCLK = ~I_MCLK;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	// Expected word starting at a byte index of the model array.
	function automatic logic [15:0] word_at(input int b);
		return wide ? {mem[b % 512], mem[(b + 1) % 512]} : {8'h00, mem[b % 512]};
	endfunction
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk_bit(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("Error %0t flag %b, expected %b", $time, g, e);
		end
	endtask
	task automatic chk_word(input logic [16:0] e, input logic [15:0] g);
		n_tests++;
		if ((e[16] ? g : {8'h00, g[7:0]}) !== e[15:0]) begin
			err_count++;
			$display("Error %0t read word %h, expected %h", $time, g, e[15:0]);
		end
	endtask
	// Issues one command, notes its expected effects and waits for its end.
	task automatic do_cmd(input tw_pkg::tw_cmd_t k, input logic [8:0] a, input logic [15:0] d,
		input logic [7:0] n);
		int i;
		int w;
		int t;
		while (cmd_ready !== 1'b1) @(posedge I_MCLK) #1;
		busy_seen = 1'b0;
		cmd_valid = 1'b1;
		cmd_kind = k;
		cmd_addr = a;
		cmd_data = d;
		rd_words = n;
		w = wide ? 2 : 1;
		i = wide ? {a[7:0], 1'b0} : a;
		case (k)
		tw_pkg::CMD_ENABLE: en = 1'b1;
		tw_pkg::CMD_DISABLE: en = 1'b0;
		tw_pkg::CMD_READ: begin
			for (int j = 0; j < n; j++) expq.push_back({wide, word_at(i + j * w)});
		end
		default: begin
			for (int b = 0; b < 512; b++) begin
				if (en && (k == tw_pkg::CMD_ERASE_ALL || k == tw_pkg::CMD_WRITE_ALL ||
					(b >= i && b < i + w)))
					mem[b] = (k == tw_pkg::CMD_ERASE || k == tw_pkg::CMD_ERASE_ALL) ? 8'hff :
						(wide && b % 2 == 0) ? d[15:8] : d[7:0];
			end
		end
		endcase
		@(posedge I_MCLK) #1;
		cmd_valid = 1'b0;
		// The done pulse is looked at one step after the edge that launches it.
		for (t = 0; t < 20000 && done !== 1'b1; t++) @(posedge I_MCLK) #1;
		if (t == 20000) begin
			err_count++;
			$display("Error %0t command never finished", $time);
			end_of_test();
		end
		#1;
		if (k inside {tw_pkg::CMD_ERASE, tw_pkg::CMD_WRITE, tw_pkg::CMD_ERASE_ALL,
			tw_pkg::CMD_WRITE_ALL}) begin
			chk_bit(busy_seen, en);
			chk_bit(busy, 1'b0);
		end
	endtask
	// Counts cycles against the ceiling and notes any programming cycle.
	always @(posedge I_MCLK) begin
		cyc++;
		if (busy === 1'b1) busy_seen = 1'b1;
		if (cyc == 60000) begin
			err_count++;
			end_of_test();
		end
	end
	// Takes the oldest expected word off the queue whenever a word arrives.
	always @(posedge I_MCLK) begin
		if (rd_valid === 1'b1) begin
			if (expq.size() == 0) chk_bit(1'b1, 1'b0);
			else chk_word(expq.pop_front(), rd_data);
		end
	end
	// Resets both ends together, runs the enable and erase-all checks in the narrow width, then the write, erase and read sequence in both widths.
	initial begin
		I_RESET_N = 1'b0;
		cmd_valid = 1'b0;
		cmd_kind = tw_pkg::CMD_READ;
		cmd_addr = 9'h000;
		cmd_data = 16'h0000;
		rd_words = 8'h00;
		wide = 1'b0;
		err_count = 0;
		n_tests = 0;
		cyc = 0;
		en = 1'b0;
		busy_seen = 1'b0;
		seed = 32'h14;
		repeat (8) @(posedge I_MCLK);
		#1;
		I_RESET_N = 1'b1;
		do_cmd(tw_pkg::CMD_WRITE, 9'h0a5, 16'h0012, 8'h00);
		do_cmd(tw_pkg::CMD_ENABLE, 9'h000, 16'h0000, 8'h00);
		do_cmd(tw_pkg::CMD_ERASE_ALL, 9'h000, 16'h0000, 8'h00);
		do_cmd(tw_pkg::CMD_READ, 9'h1fe, 16'h0000, 8'h03);
		do_cmd(tw_pkg::CMD_DISABLE, 9'h000, 16'h0000, 8'h00);
		do_cmd(tw_pkg::CMD_WRITE, 9'h005, 16'h005a, 8'h00);
		do_cmd(tw_pkg::CMD_READ, 9'h005, 16'h0000, 8'h01);
		do_cmd(tw_pkg::CMD_ENABLE, 9'h000, 16'h0000, 8'h00);
		for (int m = 0; m < 2; m++) begin
			wide = m[0];
			repeat (4) @(posedge I_MCLK);
			#1;
			for (int r = 0; r < 3; r++) begin
				seed = xs(seed);
				do_cmd(tw_pkg::CMD_WRITE, seed[8:0], seed[31:16], 8'h00);
				do_cmd(tw_pkg::CMD_READ, seed[8:0], 16'h0000, 8'h02);
			end
			do_cmd(tw_pkg::CMD_ERASE, seed[8:0], 16'h0000, 8'h00);
			do_cmd(tw_pkg::CMD_READ, seed[8:0], 16'h0000, 8'h01);
			do_cmd(tw_pkg::CMD_WRITE_ALL, 9'h000, seed[15:0] ^ 16'h3c3c, 8'h00);
			do_cmd(tw_pkg::CMD_WRITE, 9'h1ff, seed[23:8], 8'h00);
			do_cmd(tw_pkg::CMD_READ, 9'h1ff, 16'h0000, 8'h03);
		end
		chk_bit(expq.size() == 0, 1'b1);
		end_of_test();
	end
endmodule // tb
`default_nettype wire

// ### testbench/tw_assertions.sv
// Concurrent checks on the three-wire link between the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module tw_assertions #(
	parameter int PROG_CYC = 200
) (
	input wire logic I_MCLK,
	input wire logic I_RESET_N,
	input wire logic shift_clock_pin,
	input wire logic select_pin,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic O_BUSY
);
	logic stat_r;
	logic poll_r;
	int busy_cnt_r;
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RESET_N);
	// Marks a programming cycle whose status may show until select falls.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			stat_r <= 1'b0;
		end else if (O_BUSY) begin
			stat_r <= 1'b1;
		end else if (!select_pin) begin
			stat_r <= 1'b0;
		end
	end
	// Marks a select that was raised while the device was busy, until it falls.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			poll_r <= 1'b0;
		end else begin
			poll_r <= select_pin && (poll_r || ($rose(select_pin) && O_BUSY));
		end
	end
	// Counts the cycles of the current programming cycle.
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			busy_cnt_r <= 0;
		end else begin
			busy_cnt_r <= O_BUSY ? busy_cnt_r + 1 : 0;
		end
	end
	a_idle_out_hiz: assert property ((!select_pin)[*5] |-> !serial_out_oe)
		else $error("output driven with select low");
	a_read_rise_only: assert property ((!shift_clock_pin)[*4] ##0
		(select_pin && serial_out_oe && !stat_r) |-> $stable(serial_out))
		else $error("read output moved while shift clock low");
	a_busy_max: assert property (O_BUSY |-> busy_cnt_r <= PROG_CYC + 2)
		else $error("programming cycle too long");
	a_busy_full: assert property ($fell(O_BUSY) |-> $past(busy_cnt_r) >= PROG_CYC - 2)
		else $error("programming cycle too short");
	a_status_busy: assert property (poll_r[*6] ##0 O_BUSY |-> serial_out_oe && !serial_out)
		else $error("busy status not low");
	a_status_ready: assert property (poll_r[*6] ##0 (!O_BUSY && !$past(O_BUSY, 4))
		|-> serial_out_oe && serial_out)
		else $error("ready status not high");
	a_no_late_status: assert property ($rose(select_pin) && !O_BUSY &&
		!$past(O_BUSY, 8) |-> (!serial_out_oe)[*6])
		else $error("status shown with no cycle running");
	a_busy_at_frame: assert property ($rose(O_BUSY) |-> select_pin && shift_clock_pin)
		else $error("programming cycle started outside a frame");
endmodule // tw_assertions
`default_nettype wire
